/* rtl/sio_params.svh */
// register offsets, field positions, reset values and timing counts of the serial port
`ifndef SIO_PARAMS_SVH
`define SIO_PARAMS_SVH
// ****************************************************************
// register byte offsets
// ****************************************************************
`define SIO_CTRL_OFF 12'h000
`define SIO_STAT_OFF 12'h004
`define SIO_TXB_OFF 12'h008
`define SIO_RXB_OFF 12'h00c
// ****************************************************************
// control fields
// ****************************************************************
`define SIO_CTRL_START 0
`define SIO_CTRL_STOP 1
`define SIO_CTRL_MODE_LO 2
`define SIO_CTRL_ORDER 4
`define SIO_CTRL_EXTCLK 5
`define SIO_CTRL_RST 6'h00
// ****************************************************************
// status fields
// ****************************************************************
`define SIO_STAT_ACTIVE 0
`define SIO_STAT_SHIFT 1
`define SIO_STAT_TXE 2
`define SIO_STAT_RXF 3
`define SIO_STAT_TX_UNDERRUN_FLAG 4
`define SIO_STAT_RX_OVERRUN_FLAG 5
// ****************************************************************
// timing
// ****************************************************************
`define SIO_CLK_NS 4
`define SIO_HALF_NS 64
`define SIO_HALF_CYC (`SIO_HALF_NS / `SIO_CLK_NS)
`endif

/* rtl/sio_pkg.sv */
// types shared by the serial port files
package sio_pkg;
   typedef enum logic [1:0] {
      MODE_TX = 2'b00,
      MODE_RX = 2'b01,
      MODE_TXRX = 2'b10,
      MODE_RSV = 2'b11
   } mode_t;
   typedef struct packed {
      logic ext_clk;
      logic order_lsb;
      mode_t mode;
      logic stop;
      logic start;
   } ctrl_t;
   typedef struct packed {
      logic rx_overrun;
      logic tx_underrun;
      logic rx_full;
      logic tx_empty;
      logic shift_active;
      logic transfer_active;
   } stat_t;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_WAIT = 2'b10
   } state_t;
endpackage : sio_pkg

/* rtl/sio_pin_sync.sv */
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ps
module sio_pin_sync (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic pin_i,
   output logic level_o
);
   logic s1;
   logic s2;
   logic s3;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         s1 <= 1'b1;
         s2 <= 1'b1;
         s3 <= 1'b1;
      end else begin
         s1 <= pin_i;
         s2 <= s1;
         s3 <= s2;
      end
   end
   // a change counts only once two stages agree
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         level_o <= 1'b1;
      end else if (s2 == s3) begin
         level_o <= s3;
      end
   end
endmodule : sio_pin_sync

/* rtl/sio_port.sv */
// eight-bit synchronous serial port with apb register access
// Behaviour
// - clearing start during receive finishes the current byte, then clears active
// - force-stop halts at once and clears start, status and both buffers
// - external clock shift ending while receive-full is set flags overrun
// - during overrun incoming data is discarded; buffer and shifter stay unchanged
// - after overrun first read gives old byte, second read the held shifter
// - clearing overrun by reading also clears receive-full
// - after start clears, reception stops after eight more clocks
// - no interrupt requests while overrun stays set
// - mode field value 10 selects full-duplex operation
// - transmit buffer write clears empty; receive buffer read clears full
// - active flag sets on a serial clock falling edge after start
// - output changes on falling edges, input sampled on rising, chosen order
// - shift-active is high from first falling edge to eighth rising edge
// - empty sets on rising edge after load; full byte copied, flagged, interrupt
// - internal clock loads shifter within one serial period, then clocks
// - external clock first falling edge loads shifter; next rising edge receives
// - internal clock waits high until buffers serviced, resumes within one period
// - duplex external shift without new data flags underrun; interrupt after byte
// - underrun holds output high; recovery is read then force-stop
// - clearing start in duplex completes the byte, clears active, output high
// - mode field 00 selects transmit-only, 01 receive-only
// - bit order select 0 sends msb first, 1 lsb first
`timescale 1ns/1ps
`include "sio_params.svh"
module sio_port #(
   parameter int HALF_CYC = `SIO_HALF_CYC
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic sclk_in_i,
   output logic sclk_out_o,
   output logic sclk_oe_o,
   input wire logic sdata_in_i,
   output logic sdata_out_o,
   output logic irq_o
);
   sio_pkg::ctrl_t ctrl;
   sio_pkg::stat_t stat;
   sio_pkg::state_t state;
   logic [7:0] tx_buf;
   logic [7:0] rx_buf;
   logic [7:0] shreg;
   logic [7:0] err_hold;
   logic err_second;
   logic [3:0] bit_cnt;
   logic [7:0] div_cnt;
   logic int_clk;
   logic ext_lvl;
   logic data_lvl;
   logic [1:0] pin_raw;
   logic [1:0] pin_lvl;
   logic force_stop;
   logic tx_fresh;
   logic rx_read;
   logic tx_written;
   logic sck_lvl;
   logic sck_prev;
   logic fall;
   logic rise;
   logic wr;
   logic rd;
   logic do_wr_ctrl;
   logic do_wr_tx;
   logic do_rd_rx;
   logic tx_mode;
   logic rx_mode;
   logic can_go;
   logic [7:0] next_shreg;
   // ****************************************************************
   // apb slave
   // ****************************************************************
   // no wait states: every register answers in its first access cycle
   assign pready_o = 1'b1;
   assign wr = psel_i && penable_i && pwrite_i;
   assign rd = psel_i && penable_i && !pwrite_i;
   assign do_wr_ctrl = wr && (paddr_i == `SIO_CTRL_OFF);
   assign do_wr_tx = wr && (paddr_i == `SIO_TXB_OFF);
   assign do_rd_rx = rd && (paddr_i == `SIO_RXB_OFF);
   // force-stop acts in the access cycle of its write
   assign force_stop = do_wr_ctrl && pwdata_i[`SIO_CTRL_STOP];
   always_comb begin
      pslverr_o = 1'b0;
      if (psel_i && penable_i) begin
         if (paddr_i != `SIO_CTRL_OFF && paddr_i != `SIO_STAT_OFF &&
             paddr_i != `SIO_TXB_OFF && paddr_i != `SIO_RXB_OFF) begin
            pslverr_o = 1'b1;
         end
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         prdata_o <= 32'h0000_0000;
      end else if (psel_i && !penable_i && !pwrite_i) begin
         // captured in setup so the word stands through the access phase
         if (paddr_i == `SIO_CTRL_OFF) begin
            prdata_o <= {26'h0, ctrl};
         end else if (paddr_i == `SIO_STAT_OFF) begin
            prdata_o <= {26'h0, stat};
         end else if (paddr_i == `SIO_RXB_OFF) begin
            // second read after overrun shows held shifter
            prdata_o <= {24'h0, err_second ? err_hold : rx_buf};
         end else begin
            prdata_o <= 32'h0000_0000;
         end
      end
   end
   // ****************************************************************
   // control register
   // ****************************************************************
   // mode field decode
   assign tx_mode = (ctrl.mode == sio_pkg::MODE_TX) || (ctrl.mode == sio_pkg::MODE_TXRX);
   assign rx_mode = (ctrl.mode == sio_pkg::MODE_RX) || (ctrl.mode == sio_pkg::MODE_TXRX);
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         ctrl <= sio_pkg::ctrl_t'(`SIO_CTRL_RST);
      end else if (do_wr_ctrl) begin
         ctrl <= sio_pkg::ctrl_t'(pwdata_i[5:0]);
         // force-stop also clears start
         // force-stop is a strobe, so it never reads back as set
         if (pwdata_i[`SIO_CTRL_STOP]) begin
            ctrl.start <= 1'b0;
            ctrl.stop <= 1'b0;
         end
      end
   end
   // ****************************************************************
   // serial clock: internal divider or synchronised pin
   // ****************************************************************
   // both pins pass four flops before use
   // data is resynchronised too, so it lags the clock pin by the same count
   assign pin_raw = {sdata_in_i, sclk_in_i};
   for (genvar g = 0; g < 2; g++) begin : g_pin
      sio_pin_sync u_sync (
         .sys_clk_i(sys_clk_i),
         .sys_rst_i(sys_rst_i),
         .pin_i(pin_raw[g]),
         .level_o(pin_lvl[g])
      );
   end
   assign ext_lvl = pin_lvl[0];
   assign data_lvl = pin_lvl[1];
   // the divider restarts on every shift entry, giving a full first half period
   // clock idles high while waiting; toggles only in shift state
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || state != sio_pkg::ST_SHIFT || ctrl.ext_clk) begin
         div_cnt <= 8'h00;
         int_clk <= 1'b1;
      end else if (div_cnt == 8'(HALF_CYC - 1)) begin
         div_cnt <= 8'h00;
         int_clk <= !int_clk;
      end else begin
         div_cnt <= div_cnt + 8'h01;
      end
   end
   assign sclk_out_o = int_clk;
   assign sclk_oe_o = !ctrl.ext_clk;
   assign sck_lvl = ctrl.ext_clk ? ext_lvl : int_clk;
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i) begin
         sck_prev <= 1'b1;
      end else begin
         sck_prev <= sck_lvl;
      end
   end
   assign fall = sck_prev && !sck_lvl;
   assign rise = !sck_prev && sck_lvl;
   // ****************************************************************
   // transfer sequencing
   // ****************************************************************
   // resume only when both required buffer accesses were made
   // holding the clock keeps an unread byte from being overwritten
   assign can_go = (!tx_mode || tx_written) && (!rx_mode || rx_read || !stat.rx_full);
   always_comb begin
      next_shreg = shreg;
      if (ctrl.order_lsb) begin
         next_shreg = {data_lvl, shreg[7:1]};
      end else begin
         next_shreg = {shreg[6:0], data_lvl};
      end
   end
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || force_stop) begin
         // reset and force-stop clear all status and buffers
         state <= sio_pkg::ST_IDLE;
         stat <= '0;
         rx_buf <= 8'h00;
         shreg <= 8'h00;
         err_hold <= 8'h00;
         err_second <= 1'b0;
         bit_cnt <= 4'h0;
         sdata_out_o <= 1'b1;
         tx_written <= 1'b0;
         rx_read <= 1'b0;
         tx_fresh <= 1'b0;
         irq_o <= 1'b0;
      end else begin
         irq_o <= 1'b0;
         if (do_wr_tx) begin
            stat.tx_empty <= 1'b0;
            tx_written <= 1'b1;
            tx_fresh <= 1'b1;
         end
         if (do_rd_rx) begin
            rx_read <= 1'b1;
            // the first read leaves overrun set so the held byte is offered next
            if (stat.rx_overrun && !err_second) begin
               err_second <= 1'b1;
            end else if (stat.rx_overrun) begin
               stat.rx_overrun <= 1'b0;
               stat.rx_full <= 1'b0;
               err_second <= 1'b0;
            end else begin
               stat.rx_full <= 1'b0;
            end
         end
         case (state)
            sio_pkg::ST_IDLE: begin
               // internal clock begins within one period
               // an external clock needs no buffer check: the peer paces the bytes
               if (ctrl.start && (ctrl.ext_clk || can_go)) begin
                  state <= sio_pkg::ST_SHIFT;
                  bit_cnt <= 4'h0;
               end
            end
            sio_pkg::ST_SHIFT: begin
               if (fall && bit_cnt < 4'h8) begin
                  stat.transfer_active <= 1'b1;
                  stat.shift_active <= 1'b1;
                  if (bit_cnt == 4'h0) begin
                     if (tx_mode && !tx_fresh && ctrl.ext_clk && !do_wr_tx) begin
                        stat.tx_underrun <= 1'b1;
                     end
                     tx_fresh <= 1'b0;
                     tx_written <= 1'b0;
                     rx_read <= 1'b0;
                     // overrun freezes the shifter; the second read takes its byte from err_hold
                     if (!stat.rx_overrun) begin
                        shreg <= tx_buf;
                     end
                     // output on falling edge in chosen order
                     sdata_out_o <= !tx_mode || stat.tx_underrun ||
                        (tx_mode && !tx_fresh && ctrl.ext_clk) ||
                        (ctrl.order_lsb ? tx_buf[0] : tx_buf[7]);
                  end else begin
                     sdata_out_o <= !tx_mode || stat.tx_underrun ||
                        (ctrl.order_lsb ? shreg[0] : shreg[7]);
                  end
               end
               if (rise && stat.shift_active) begin
                  // empty sets on rising edge after load
                  if (bit_cnt == 4'h0 && tx_mode && !stat.tx_underrun) begin
                     stat.tx_empty <= 1'b1;
                  end
                  if (!stat.rx_overrun) begin
                     shreg <= next_shreg;
                  end
                  bit_cnt <= bit_cnt + 4'h1;
                  if (bit_cnt == 4'h7) begin
                     stat.shift_active <= 1'b0;
                     if (stat.rx_overrun) begin
                        irq_o <= 1'b0;
                     end else if (rx_mode && stat.rx_full && ctrl.ext_clk) begin
                        // overrun with unread buffer
                        // only an external clock can overrun; the internal one waits instead
                        stat.rx_overrun <= 1'b1;
                        err_hold <= next_shreg;
                     end else begin
                        if (rx_mode) begin
                           rx_buf <= next_shreg;
                           stat.rx_full <= 1'b1;
                        end
                        irq_o <= 1'b1;
                     end
                     if (!ctrl.start) begin
                        state <= sio_pkg::ST_IDLE;
                        stat.transfer_active <= 1'b0;
                        sdata_out_o <= 1'b1;
                     end else if (!ctrl.ext_clk) begin
                        state <= sio_pkg::ST_WAIT;
                     end else begin
                        bit_cnt <= 4'h0;
                     end
                  end
               end
            end
            sio_pkg::ST_WAIT: begin
               // hold clock high until serviced
               // only the internal clock ever reaches this wait
               if (!ctrl.start) begin
                  state <= sio_pkg::ST_IDLE;
                  stat.transfer_active <= 1'b0;
                  sdata_out_o <= 1'b1;
               end else if (can_go) begin
                  state <= sio_pkg::ST_SHIFT;
                  bit_cnt <= 4'h0;
               end
            end
            default: begin
               state <= sio_pkg::ST_IDLE;
            end
         endcase
      end
   end
   // ****************************************************************
   // transmit buffer
   // ****************************************************************
   // a write loads the buffer; force-stop empties it
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || force_stop) begin
         tx_buf <= 8'h00;
      end else if (do_wr_tx) begin
         tx_buf <= pwdata_i[7:0];
      end
   end
endmodule : sio_port

/* tb/sio_port_monitor.sv */
// checker of bus answers, pin idle levels and serial clock timing
`timescale 1ns/1ps
module sio_port_monitor #(
   parameter int HALF_CYC = 16
) (
   input wire logic sys_clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic sclk_out_o,
   input wire logic sclk_oe_o,
   input wire logic sdata_out_o,
   input wire logic irq_o
);
   default clocking cb @(posedge sys_clk_i);
   endclocking
   default disable iff (sys_rst_i);
   logic acc;
   logic unmapped;
   logic ctl_wr;
   int low_len;
   assign acc = psel_i && penable_i;
   assign unmapped = (paddr_i > 12'h00c) || (paddr_i[1:0] != 2'b00);
   assign ctl_wr = acc && pwrite_i && (paddr_i == 12'h000);
   // low half length, cleared while the clock is high
   always_ff @(posedge sys_clk_i) begin
      if (sys_rst_i || sclk_out_o) begin
         low_len <= 0;
      end else begin
         low_len <= low_len + 1;
      end
   end
   // ****
   // checks
   // ****
   chk_ready_zero_wait: assert property (acc |-> pready_o)
      else $error("access not answered in its first cycle");
   chk_slverr_unmapped: assert property (acc |-> pslverr_o == unmapped)
      else $error("error response does not match the address map");
   chk_unmapped_read_zero: assert property (acc && !pwrite_i && unmapped |-> prdata_o == 32'h0)
      else $error("unmapped read returned data");
   chk_reset_idle_high: assert property ($fell(sys_rst_i) |-> sdata_out_o && sclk_out_o && !irq_o)
      else $error("pins not idle after reset");
   chk_clock_source_oe: assert property (ctl_wr |=> sclk_oe_o == !$past(pwdata_i[5]))
      else $error("clock drive does not follow the clock source");
   chk_low_half_len: assert property (sclk_oe_o && $rose(sclk_out_o) |-> low_len == HALF_CYC)
      else $error("serial clock low half has the wrong length");
   chk_irq_one_cycle: assert property (irq_o |=> !irq_o)
      else $error("interrupt pulse longer than one cycle");
   chk_data_low_stable: assert property (sclk_oe_o && !sclk_out_o && !$past(sclk_out_o, 2)
      |-> $stable(sdata_out_o))
      else $error("serial output moved while the clock was low");
   chk_stop_goes_idle: assert property (ctl_wr && pwdata_i[1] |-> ##[1:3] sdata_out_o && sclk_out_o)
      else $error("force stop did not idle the pins");
endmodule : sio_port_monitor
bind sio_port sio_port_monitor #(.HALF_CYC(HALF_CYC)) u_monitor (
   .sys_clk_i(sys_clk_i),
   .sys_rst_i(sys_rst_i),
   .psel_i(psel_i),
   .penable_i(penable_i),
   .pwrite_i(pwrite_i),
   .paddr_i(paddr_i),
   .pwdata_i(pwdata_i),
   .prdata_o(prdata_o),
   .pready_o(pready_o),
   .pslverr_o(pslverr_o),
   .sclk_out_o(sclk_out_o),
   .sclk_oe_o(sclk_oe_o),
   .sdata_out_o(sdata_out_o),
   .irq_o(irq_o)
);

/* tb/sio_peer.sv */
// behavioural external serial peer on the shared clock pin
`timescale 1ns/1ps
module sio_peer (
   input wire logic sclk_pin_i,
   input wire logic sdata_i,
   input wire logic lsb_i,
   input wire logic [7:0] tx_byte_i,
   output logic ext_clk_o,
   output logic sdata_o,
   output logic [7:0] rx_byte_o
);
   logic [7:0] shreg;
   logic [7:0] inreg;
   int bit_n;
   logic in_frame;
   initial begin
      ext_clk_o = 1'b1;
      sdata_o = 1'b1;
      rx_byte_o = 8'h00;
      bit_n = 0;
      in_frame = 1'b0;
   end
   // drive on fall in the chosen order; a frame opens on a fall
   always @(negedge sclk_pin_i) begin
      if (!in_frame) begin
         shreg = tx_byte_i;
         bit_n = 0;
         in_frame = 1'b1;
      end
      sdata_o = lsb_i ? shreg[bit_n] : shreg[7 - bit_n];
   end
   // sample on rise, hand over after eight; the pin settling after reset is no bit
   always @(posedge sclk_pin_i) begin
      if (in_frame) begin
         inreg = lsb_i ? {sdata_i, inreg[7:1]} : {inreg[6:0], sdata_i};
         bit_n = bit_n + 1;
         if (bit_n == 8) begin
            rx_byte_o = inreg;
            bit_n = 0;
            in_frame = 1'b0;
         end
      end
   end
   // clock stands high outside frames, caller paces the bytes
   task automatic pulses(input int n);
      repeat (n) begin
         #62.5 ext_clk_o = 1'b0;
         #62.5 ext_clk_o = 1'b1;
      end
   endtask : pulses
endmodule : sio_peer

/* tb/sync_serial_rx_txrx_control_tb.sv */
// self-checking bench of the serial port with a peer on the link
`timescale 1ns/1ps
`include "sio_params.svh"
module sync_serial_rx_txrx_control_tb;
   localparam int HALF = 8;
   localparam logic [11:0] a_ctl = `SIO_CTRL_OFF;
   localparam logic [11:0] a_sta = `SIO_STAT_OFF;
   localparam logic [11:0] a_txb = `SIO_TXB_OFF;
   localparam logic [11:0] a_rxb = `SIO_RXB_OFF;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic sclk_out;
   logic sclk_oe;
   logic sdata_out;
   logic irq;
   logic ext_clk;
   logic peer_data;
   logic peer_lsb = 1'b0;
   logic [7:0] peer_tx = 8'h00;
   logic [7:0] peer_rx;
   logic [7:0] t;
   logic [7:0] r;
   logic [7:0] b [3];
   logic [31:0] q;
   wire sclk_pin = sclk_oe ? sclk_out : ext_clk;
   int bad_count = 0;
   int samples_checked = 0;
   int irq_seen = 0;
   int n;
   always #2 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irq_seen++;
   sio_port #(.HALF_CYC(HALF)) u_dut (.sys_clk_i(clk), .sys_rst_i(rst), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(), .sclk_in_i(sclk_pin),
      .sclk_out_o(sclk_out), .sclk_oe_o(sclk_oe), .sdata_in_i(peer_data),
      .sdata_out_o(sdata_out), .irq_o(irq));
   sio_peer u_peer (.sclk_pin_i(sclk_pin), .sdata_i(sdata_out), .lsb_i(peer_lsb),
      .tx_byte_i(peer_tx), .ext_clk_o(ext_clk), .sdata_o(peer_data), .rx_byte_o(peer_rx));
   // ****
   // tasks
   // ****
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      q = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] mask,
         input logic [31:0] exp);
      apb(1'b0, a, 32'h0);
      check(what, q & mask, exp);
   endtask : rdc
   task automatic poll_active();
      for (int i = 0; i < 80; i++) begin
         apb(1'b0, a_sta, 32'h0);
         if (q[0] === 1'b0) break;
      end
   endtask : poll_active
   task automatic wait_irq(input int k);
      for (int i = 0; i < 2000 && irq_seen < k; i++) @(posedge clk);
   endtask : wait_irq
   function automatic logic [31:0] ctl(input logic st, input logic [1:0] m, input logic lsb,
         input logic ext);
      return {26'h0, ext, lsb, m, 1'b0, st};
   endfunction : ctl
   task automatic close_out();
      $display("checks %0d mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : close_out
   initial begin
      #100000;
      bad_count++;
      close_out();
   end
   // ****
   // stimulus
   // ****
   initial begin
      void'($urandom(32'h989e2179));
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      rdc("control", a_ctl, 32'hffffffff, 32'h0);
      rdc("status", a_sta, 32'h3f, 32'h0);
      check("serial out", sdata_out, 1'b1);
      rdc("unmapped", 12'h010, 32'hffffffff, 32'h0);
      // the three non-reserved modes and both orders on the internal clock
      for (int m = 0; m < 3; m++) begin
         for (int o = 0; o < 2; o++) begin
            t = 8'($urandom);
            r = 8'($urandom);
            peer_tx <= r;
            peer_lsb <= o[0];
            if (m != 1) begin
               apb(1'b1, a_txb, {24'h0, t});
               rdc("tx empty", a_sta, 32'h4, 32'h0);
            end
            n = irq_seen + 1;
            apb(1'b1, a_ctl, ctl(1'b1, m[1:0], o[0], 1'b0));
            wait_irq(n);
            check("interrupt", irq_seen, n);
            repeat (3 * HALF) @(posedge clk);
            check("clock parked", sclk_out, 1'b1);
            apb(1'b1, a_ctl, ctl(1'b0, m[1:0], o[0], 1'b0));
            if (m != 1) begin
               check("peer byte", peer_rx, t);
               rdc("tx empty", a_sta, 32'h4, 32'h4);
            end
            if (m != 0) begin
               rdc("rx full", a_sta, 32'h8, 32'h8);
               rdc("rx byte", a_rxb, 32'hff, r);
               rdc("rx full", a_sta, 32'h8, 32'h0);
            end
            poll_active();
            check("active", q[0], 1'b0);
            check("serial out", sdata_out, 1'b1);
         end
      end
      // external receive left unread until overrun
      peer_lsb <= 1'b0;
      n = irq_seen;
      apb(1'b1, a_ctl, ctl(1'b1, 2'b01, 1'b0, 1'b1));
      rdc("active", a_sta, 32'h1, 32'h0);
      for (int k = 0; k < 3; k++) begin
         b[k] = 8'($urandom);
         peer_tx <= b[k];
         @(posedge clk);
         u_peer.pulses(8);
         repeat (8) @(posedge clk);
         if (k == 0) rdc("active", a_sta, 32'h1, 32'h1);
      end
      check("interrupt", irq_seen, n + 1);
      rdc("overrun", a_sta, 32'h38, 32'h28);
      apb(1'b1, a_ctl, ctl(1'b0, 2'b01, 1'b0, 1'b1));
      rdc("rx old", a_rxb, 32'hff, b[0]);
      rdc("rx held", a_rxb, 32'hff, b[1]);
      rdc("overrun gone", a_sta, 32'h28, 32'h0);
      u_peer.pulses(8);
      repeat (8) @(posedge clk);
      rdc("active", a_sta, 32'h1, 32'h0);
      rdc("rx after stop", a_rxb, 32'hff, b[2]);
      // duplex with no transmit byte, then force stop
      n = irq_seen;
      apb(1'b1, a_ctl, ctl(1'b1, 2'b10, 1'b0, 1'b1));
      r = 8'($urandom);
      peer_tx <= r;
      @(posedge clk);
      u_peer.pulses(1);
      repeat (8) @(posedge clk);
      rdc("underrun", a_sta, 32'h10, 32'h10);
      check("early interrupt", irq_seen, n);
      u_peer.pulses(7);
      repeat (8) @(posedge clk);
      check("interrupt", irq_seen, n + 1);
      check("peer byte", peer_rx, 8'hff);
      rdc("rx byte", a_rxb, 32'hff, r);
      apb(1'b1, a_ctl, 32'h2);
      rdc("control", a_ctl, 32'h3, 32'h0);
      rdc("status", a_sta, 32'h3f, 32'h0);
      rdc("rx cleared", a_rxb, 32'hff, 32'h0);
      close_out();
   end
endmodule : sync_serial_rx_txrx_control_tb
